// ==== verilog/bus_pins_core.sv ====
// Bus and interrupt pin logic of an 8-bit-bus processor, small configuration
//
// Behaviour
// RL1: Mid address pins carry A15-A8, float in hold
// RL2: Low pins share address/data, float hold, acknowledge
// RL3: Word transfer is low byte then high byte
// RL4: NMI rising edge caught anytime, served vector 2
// RL5: NMI source holds high five clocks minimum
// RL6: Hold beats NMI beats INT, even mid-acknowledge; code grants hold only from idle, after the acknowledge cycle ends
// RL7: Simultaneous requests: NMI served before INT
// RL8: INT sampled last instruction cycle, needs enable
// RL9: INT source holds until first acknowledge pulse
// RL10: Accepted INT pulses acknowledge, vector read back
// RL11: Reset overrides all, fetch starts at FFFF0
// RL12: Reset, NMI or INT wake from standby
// RL13: Ready low inserts waits, high ends them
// RL14: System synchronises ready to the clock
// RL15: Poll high rechecked every five clocks
// RL16: Standby holds acknowledge and buffer enable high
// RL17: Address strobe pulses; standby: brief high, low
// RL18: Buffer enable active on every data transfer
// RL19: Buffer enable floats during hold acknowledge
// RL20: Hold acknowledge floats all three-state outputs
// RL21: Everything runs on the single clock edge
`timescale 1ns/1ps
`include "bus_pins_params.svh"
module bus_pins_core (
    input wire logic sys_clk_in, // System clock, 200 MHz
    input wire logic sys_rst_in, // Synchronous reset, active high
    input wire logic nmi_pin_in, // Non-maskable request, rising edge
    input wire logic irq_pin_in, // Maskable request, high level
    input wire logic bus_hold_request_in, // Bus hold request, high
    input wire logic ready_pin_in, // Ready, low adds wait states
    input wire logic poll_n_pin_in, // Poll input, low lets poll finish
    input wire logic [7:0] low_addr_data_pins_in, // Low address/data pins in
    output logic [7:0] low_addr_data_pins_out, // Low address/data pins out
    output logic low_addr_data_oe_n_out, // Low pins enable, low drives
    output logic [7:0] mid_address_pins_out, // Address bits 15 to 8
    output logic mid_address_oe_n_out, // Mid pins enable, low drives
    output logic address_latch_strobe_out, // Address latch strobe
    output logic irq_acknowledge_n_out, // Interrupt acknowledge, low
    output logic buffer_output_enable_n_out, // Buffer enable, low
    output logic buffer_output_enable_oe_n_out, // Buffer enable pin enable
    output logic bus_hold_acknowledge_out, // Hold acknowledge, high
    input wire logic cmd_valid_in, // Bus cycle request
    input wire logic cmd_write_in, // Request is a write
    input wire logic cmd_word_in, // Request is a 16-bit transfer
    input wire logic [19:0] cmd_addr_in, // Request address
    input wire logic [15:0] cmd_wdata_in, // Write data
    output logic cmd_ready_out, // Request can be taken
    output logic cmd_done_out, // Bus request finished, pulse
    output logic [15:0] cmd_rdata_out, // Read data
    input wire logic instr_last_in, // Last cycle of an instruction
    input wire logic irq_enable_flag_in, // Maskable interrupts enabled
    output logic irq_take_out, // Interrupt taken, pulse
    output logic [7:0] irq_vector_out, // Vector of the taken interrupt
    input wire logic poll_start_in, // Poll instruction begins, pulse
    output logic poll_done_out, // Poll satisfied, pulse
    input wire logic standby_enter_in, // Enter standby request
    output logic standby_out, // In standby
    output logic fetch_start_out, // Program start after reset, pulse
    output logic [19:0] fetch_addr_out // Program start address
);

    pin_sync_if #(.WIDTH(`SYNC_WIDTH)) sync_bus ();

    bus_pins_pkg::bus_state_type state_q;
    bus_pins_pkg::cycle_kind_type kind_q;
    logic hold_c;
    logic nmi_c;
    logic irq_c;
    logic rdy_c;
    logic poll_n_c;
    logic nmi_prev_q;
    logic nmi_edge;
    logic nmi_pend_q;
    logic inta_pend_q;
    logic inta_start;
    logic word_q;
    logic second_q;
    logic [19:0] addr_q;
    logic [15:0] wdata_q;
    logic poll_busy_q;
    logic [2:0] poll_cnt_q;
    logic boot_q;

    // Pin inputs through the synchroniser
    assign sync_bus.raw = {poll_n_pin_in, ready_pin_in, bus_hold_request_in, irq_pin_in, nmi_pin_in};
    assign nmi_c = sync_bus.clean[`SYNC_NMI_BIT];
    assign irq_c = sync_bus.clean[`SYNC_IRQ_BIT];
    assign hold_c = sync_bus.clean[`SYNC_HOLD_BIT];
    assign rdy_c = sync_bus.clean[`SYNC_READY_BIT]; // see RL14
    assign poll_n_c = sync_bus.clean[`SYNC_POLL_BIT];

    pin_input_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .sync_port(sync_bus.filter)
    );

    // Edge of NMI and start condition of an acknowledge cycle
    assign nmi_edge = nmi_c & ~nmi_prev_q; // see RL4
    assign inta_start = (state_q == bus_pins_pkg::ST_IDLE) && !(cmd_valid_in && cmd_ready_out)
        && !hold_c && inta_pend_q; // see RL6

    // Interrupt capture, priority and vector report
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
            inta_pend_q <= 1'b0;
            irq_take_out <= 1'b0;
            irq_vector_out <= `PINS_BYTE_RESET;
        end else begin
            nmi_prev_q <= nmi_c;
            irq_take_out <= 1'b0;
            if (nmi_edge) begin
                nmi_pend_q <= 1'b1; // see RL4
            end else if (instr_last_in && nmi_pend_q) begin
                nmi_pend_q <= 1'b0;
            end
            if (instr_last_in && nmi_pend_q) begin
                irq_take_out <= 1'b1; // see RL7
                irq_vector_out <= `NMI_VECTOR_NUM; // see RL4
            end else if (state_q == bus_pins_pkg::ST_T4 && kind_q == bus_pins_pkg::CYC_INTA) begin
                irq_take_out <= 1'b1;
                irq_vector_out <= low_addr_data_pins_in; // see RL10
            end
            if (instr_last_in && !nmi_pend_q && irq_c && irq_enable_flag_in && !inta_pend_q) begin
                inta_pend_q <= 1'b1; // see RL8
            end else if (inta_start) begin
                inta_pend_q <= 1'b0;
            end
        end
    end

    // Bus cycle sequencer with hold and standby
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin // see RL11 see RL21
            state_q <= bus_pins_pkg::ST_IDLE;
            kind_q <= bus_pins_pkg::CYC_READ;
            word_q <= 1'b0;
            second_q <= 1'b0;
            addr_q <= `FETCH_START_ADDR;
            wdata_q <= `PINS_WORD_RESET;
            cmd_ready_out <= 1'b0;
            cmd_done_out <= 1'b0;
            cmd_rdata_out <= `PINS_WORD_RESET;
            low_addr_data_pins_out <= `PINS_BYTE_RESET;
            low_addr_data_oe_n_out <= 1'b1;
            mid_address_pins_out <= `PINS_BYTE_RESET;
            mid_address_oe_n_out <= 1'b1;
            address_latch_strobe_out <= 1'b0;
            irq_acknowledge_n_out <= 1'b1;
            buffer_output_enable_n_out <= 1'b1;
            buffer_output_enable_oe_n_out <= 1'b0;
            bus_hold_acknowledge_out <= 1'b0;
            standby_out <= 1'b0;
        end else begin
            cmd_done_out <= 1'b0;
            case (state_q)
                bus_pins_pkg::ST_IDLE: begin
                    if (cmd_valid_in && cmd_ready_out) begin
                        state_q <= bus_pins_pkg::ST_T1;
                        kind_q <= cmd_write_in ? bus_pins_pkg::CYC_WRITE : bus_pins_pkg::CYC_READ;
                        word_q <= cmd_word_in;
                        second_q <= 1'b0;
                        addr_q <= cmd_addr_in;
                        wdata_q <= cmd_wdata_in;
                        cmd_ready_out <= 1'b0;
                    end else if (hold_c) begin
                        state_q <= bus_pins_pkg::ST_HOLD; // see RL6
                        bus_hold_acknowledge_out <= 1'b1;
                        low_addr_data_oe_n_out <= 1'b1; // see RL20
                        mid_address_oe_n_out <= 1'b1; // see RL1
                        buffer_output_enable_oe_n_out <= 1'b1; // see RL19
                        cmd_ready_out <= 1'b0;
                    end else if (inta_start) begin
                        state_q <= bus_pins_pkg::ST_T1;
                        kind_q <= bus_pins_pkg::CYC_INTA;
                        word_q <= 1'b0;
                        second_q <= 1'b0;
                        cmd_ready_out <= 1'b0;
                    end else if (standby_enter_in) begin
                        state_q <= bus_pins_pkg::ST_STANDBY;
                        standby_out <= 1'b1;
                        address_latch_strobe_out <= 1'b1; // see RL17
                        irq_acknowledge_n_out <= 1'b1; // see RL16
                        buffer_output_enable_n_out <= 1'b1; // see RL16
                        cmd_ready_out <= 1'b0;
                    end else begin
                        cmd_ready_out <= 1'b1;
                    end
                end
                bus_pins_pkg::ST_T1: begin
                    state_q <= bus_pins_pkg::ST_T2;
                    address_latch_strobe_out <= 1'b1; // see RL17
                    mid_address_pins_out <= addr_q[15:8]; // see RL1
                    mid_address_oe_n_out <= 1'b0;
                    low_addr_data_pins_out <= addr_q[7:0]; // see RL2
                    low_addr_data_oe_n_out <= (kind_q == bus_pins_pkg::CYC_INTA); // see RL2
                end
                bus_pins_pkg::ST_T2: begin
                    state_q <= bus_pins_pkg::ST_T3;
                    address_latch_strobe_out <= 1'b0;
                    buffer_output_enable_n_out <= 1'b0; // see RL18
                    if (kind_q == bus_pins_pkg::CYC_WRITE) begin
                        low_addr_data_pins_out <= second_q ? wdata_q[15:8] : wdata_q[7:0]; // see RL3
                        low_addr_data_oe_n_out <= 1'b0;
                    end else begin
                        low_addr_data_oe_n_out <= 1'b1;
                    end
                    if (kind_q == bus_pins_pkg::CYC_INTA) begin
                        irq_acknowledge_n_out <= 1'b0; // see RL10
                    end
                end
                bus_pins_pkg::ST_T3, bus_pins_pkg::ST_TW: begin
                    state_q <= rdy_c ? bus_pins_pkg::ST_T4 : bus_pins_pkg::ST_TW; // see RL13
                end
                bus_pins_pkg::ST_T4: begin
                    buffer_output_enable_n_out <= 1'b1;
                    irq_acknowledge_n_out <= 1'b1;
                    low_addr_data_oe_n_out <= 1'b1;
                    if (kind_q == bus_pins_pkg::CYC_READ) begin
                        if (second_q) begin
                            cmd_rdata_out[15:8] <= low_addr_data_pins_in; // see RL3
                        end else begin
                            cmd_rdata_out[7:0] <= low_addr_data_pins_in;
                        end
                    end
                    if (word_q && !second_q) begin
                        state_q <= bus_pins_pkg::ST_T1; // see RL3
                        second_q <= 1'b1;
                        addr_q <= addr_q + 20'h00001;
                    end else begin
                        state_q <= bus_pins_pkg::ST_IDLE;
                        cmd_done_out <= (kind_q != bus_pins_pkg::CYC_INTA);
                    end
                end
                bus_pins_pkg::ST_HOLD: begin
                    if (!hold_c) begin
                        state_q <= bus_pins_pkg::ST_IDLE;
                        bus_hold_acknowledge_out <= 1'b0;
                        buffer_output_enable_oe_n_out <= 1'b0;
                    end
                end
                bus_pins_pkg::ST_STANDBY: begin
                    address_latch_strobe_out <= 1'b0; // see RL17
                    if (nmi_edge || irq_c) begin
                        state_q <= bus_pins_pkg::ST_IDLE; // see RL12
                        standby_out <= 1'b0;
                    end
                end
                default: begin
                    state_q <= bus_pins_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Poll input recheck every five clocks
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            poll_busy_q <= 1'b0;
            poll_cnt_q <= `POLL_CNT_RESET;
            poll_done_out <= 1'b0;
        end else begin
            poll_done_out <= 1'b0;
            if (poll_start_in && !poll_busy_q) begin
                if (!poll_n_c) begin
                    poll_done_out <= 1'b1; // see RL15
                end else begin
                    poll_busy_q <= 1'b1;
                    poll_cnt_q <= `POLL_CNT_RESET;
                end
            end else if (poll_busy_q) begin
                if (poll_cnt_q == `POLL_RECHECK_CYC - 3'h1) begin
                    poll_cnt_q <= `POLL_CNT_RESET;
                    if (!poll_n_c) begin
                        poll_busy_q <= 1'b0; // see RL15
                        poll_done_out <= 1'b1;
                    end
                end else begin
                    poll_cnt_q <= poll_cnt_q + 3'h1;
                end
            end
        end
    end

    // Program start notice after reset release
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            boot_q <= 1'b1;
            fetch_start_out <= 1'b0;
            fetch_addr_out <= `FETCH_START_ADDR; // see RL11
        end else begin
            boot_q <= 1'b0;
            fetch_start_out <= boot_q; // see RL11
        end
    end

    // Standby entry shows a strobe of one clock, then stays low
    sequence seq_standby_entry;
        state_q == bus_pins_pkg::ST_IDLE && !(cmd_valid_in && cmd_ready_out) && !hold_c
            && !inta_start && standby_enter_in;
    endsequence

    sequence seq_strobe_blip;
        address_latch_strobe_out ##1 !address_latch_strobe_out;
    endsequence

    // First byte of a word handing over to the second
    sequence seq_first_byte_end;
        state_q == bus_pins_pkg::ST_T4 && word_q && !second_q;
    endsequence

    AST_MID_FLOAT_HOLD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL1
        bus_hold_acknowledge_out |-> mid_address_oe_n_out && low_addr_data_oe_n_out)
        else $error("address pins driven during hold acknowledge");
    AST_LOW_FLOAT_INTA: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL2
        !irq_acknowledge_n_out |-> low_addr_data_oe_n_out)
        else $error("low pins driven during interrupt acknowledge");
    AST_WORD_ORDER: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL3
        seq_first_byte_end |=> state_q == bus_pins_pkg::ST_T1 && second_q && addr_q == $past(addr_q) + 20'h00001)
        else $error("second byte of a word did not follow the first");
    AST_NMI_CAPTURE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL4
        nmi_edge |=> nmi_pend_q)
        else $error("nmi edge not captured");
    AST_NMI_SERVED: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL7
        instr_last_in && nmi_pend_q |=> irq_take_out && irq_vector_out == `NMI_VECTOR_NUM && !$rose(inta_pend_q))
        else $error("nmi not served with vector 2 ahead of int");
    AST_HOLD_FIRST: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL6
        state_q == bus_pins_pkg::ST_IDLE && hold_c && !(cmd_valid_in && cmd_ready_out)
        |=> bus_hold_acknowledge_out && state_q == bus_pins_pkg::ST_HOLD)
        else $error("hold request not granted first");
    AST_INT_MASKED: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL8
        instr_last_in && !irq_enable_flag_in && !inta_pend_q |=> !inta_pend_q)
        else $error("masked interrupt accepted");
    AST_INTA_PULSE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL10
        inta_start |=> ##2 !irq_acknowledge_n_out && !buffer_output_enable_n_out)
        else $error("acknowledge pulse missing in interrupt cycle");
    AST_START_ADDR: assert property (@(posedge sys_clk_in) // see RL11
        $fell(sys_rst_in) |=> fetch_start_out && fetch_addr_out == `FETCH_START_ADDR)
        else $error("program start not announced at FFFF0");
    AST_WAKE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL12
        state_q == bus_pins_pkg::ST_STANDBY && (nmi_edge || irq_c) |=> state_q == bus_pins_pkg::ST_IDLE && !standby_out)
        else $error("standby not released");
    AST_WAIT_STATE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL13
        (state_q == bus_pins_pkg::ST_T3 || state_q == bus_pins_pkg::ST_TW)
        |=> state_q == ($past(rdy_c) ? bus_pins_pkg::ST_T4 : bus_pins_pkg::ST_TW))
        else $error("wait state not following ready");
    AST_POLL_PERIOD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL15
        poll_busy_q && poll_cnt_q == `POLL_CNT_RESET
        |-> ##4 poll_busy_q ##1 poll_done_out == !$past(poll_n_c))
        else $error("poll recheck period wrong");
    AST_STANDBY_OUTS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL16
        standby_out |-> irq_acknowledge_n_out && buffer_output_enable_n_out)
        else $error("acknowledge or buffer enable active in standby");
    AST_STANDBY_STROBE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL17
        seq_standby_entry |=> seq_strobe_blip)
        else $error("strobe not one clock high on standby entry");
    AST_BUFFER_OUTPUT_ENABLE_FLOAT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // see RL19
        bus_hold_acknowledge_out |-> buffer_output_enable_oe_n_out)
        else $error("buffer enable driven during hold acknowledge");

endmodule

// ==== verilog/bus_pins_params.svh ====
// Constants for the processor bus and interrupt pin block
`ifndef BUS_PINS_PARAMS_SVH
`define BUS_PINS_PARAMS_SVH

`define CLK_PERIOD_NS 5
`define FETCH_START_ADDR 20'hFFFF0
`define NMI_VECTOR_NUM 8'h02
`define POLL_RECHECK_CYC 3'h5
`define POLL_CNT_RESET 3'h0
`define SYNC_WIDTH 5
`define SYNC_NMI_BIT 0
`define SYNC_IRQ_BIT 1
`define SYNC_HOLD_BIT 2
`define SYNC_READY_BIT 3
`define SYNC_POLL_BIT 4
`define PINS_BYTE_RESET 8'h00
`define PINS_WORD_RESET 16'h0000

`endif

// ==== verilog/bus_pins_pkg.sv ====
// Types shared by the bus and interrupt pin block
package bus_pins_pkg;

    typedef enum {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HOLD, ST_STANDBY} bus_state_type;

    typedef enum {CYC_READ, CYC_WRITE, CYC_INTA} cycle_kind_type;

endpackage

// ==== verilog/pin_sync_if.sv ====
// Carrier between the pin synchroniser and the bus core
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 5);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;

    modport filter (input raw, output clean);
    modport core (output raw, input clean);
endinterface

// ==== verilog/pin_input_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_input_sync #(
    parameter int WIDTH = 5
) (
    input wire logic sys_clk_in, // System clock
    input wire logic sys_rst_in, // Synchronous reset, active high
    pin_sync_if.filter sync_port // Raw pins in, filtered levels out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gen_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic clean_q;

            // Chain of three flops, change taken once stages two and three agree
            always_ff @(posedge sys_clk_in) begin
                if (sys_rst_in) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    clean_q <= 1'b0;
                end else begin
                    s1_q <= sync_port.raw[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        clean_q <= s3_q;
                    end
                end
            end

            assign sync_port.clean[i] = clean_q;
        end
    endgenerate

endmodule

// ==== test/far_side_model.sv ====
// Memory, interrupt controller and ready source facing the processor pins
`timescale 1ns/1ps
module far_side_model #(
    parameter logic [7:0] VECTOR = 8'h5C
) (
    input wire logic clk_in, // System clock
    input wire logic [7:0] mid_in, // Address bits 15 to 8
    input wire logic [7:0] low_in, // Low pins as driven by the core
    input wire logic low_oe_n_in, // Low pins enable, low drives
    input wire logic strobe_in, // Address latch strobe
    input wire logic ack_n_in, // Interrupt acknowledge
    input wire logic buffer_output_enable_n_in, // Buffer enable
    input wire logic [3:0] wait_in, // Wait clocks, zero is prompt
    output logic [7:0] pins_out, // Value returned on low pins
    output logic ready_out // Ready, already clock aligned
);
    logic [15:0] addr_q = 16'h0000;
    logic [4:0] stall_q = 5'h00;
    logic [7:0] last_q = 8'h00;
    // Latch address on strobe, count stall, remember last pin value
    always @(posedge clk_in) begin
        if (strobe_in === 1'b1) begin
            addr_q <= {mid_in, low_in};
            stall_q <= {1'b0, wait_in} + 5'h06;
        end else if (stall_q != 5'h00) begin
            stall_q <= stall_q - 5'h01;
        end
        last_q <= pins_out;
    end
    // Slow device keeps ready low except a short window, synchronous to clock
    assign ready_out = (wait_in == 4'h0) || (stall_q != 5'h00 && stall_q <= 5'h06);
    // Vector during acknowledge, data during buffer enable, else a changing pattern
    always_comb begin
        if (ack_n_in === 1'b0 && low_oe_n_in === 1'b1) begin
            pins_out = VECTOR;
        end else if (buffer_output_enable_n_in === 1'b0 && low_oe_n_in === 1'b1) begin
            pins_out = addr_q[7:0] ^ addr_q[15:8] ^ 8'hA5;
        end else begin
            pins_out = ~last_q;
        end
    end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the processor bus and interrupt pin block
`timescale 1ns/1ps
module tb;
    logic sys_clk_in = 0;
    logic sys_rst_in = 1;
    logic nmi_pin_in = 0;
    logic irq_pin_in = 0;
    logic bus_hold_request_in = 0;
    logic ready_pin_in;
    logic poll_n_pin_in = 0;
    logic [7:0] low_addr_data_pins_in;
    logic [7:0] low_addr_data_pins_out;
    logic low_addr_data_oe_n_out;
    logic [7:0] mid_address_pins_out;
    logic mid_address_oe_n_out;
    logic address_latch_strobe_out;
    logic irq_acknowledge_n_out;
    logic buffer_output_enable_n_out;
    logic buffer_output_enable_oe_n_out;
    logic bus_hold_acknowledge_out;
    logic cmd_valid_in = 0;
    logic cmd_write_in = 0;
    logic cmd_word_in = 0;
    logic [19:0] cmd_addr_in = 20'h00000;
    logic [15:0] cmd_wdata_in = 16'h0000;
    logic cmd_ready_out;
    logic cmd_done_out;
    logic [15:0] cmd_rdata_out;
    logic instr_last_in = 0;
    logic irq_enable_flag_in = 0;
    logic irq_take_out;
    logic [7:0] irq_vector_out;
    logic poll_start_in = 0;
    logic poll_done_out;
    logic standby_enter_in = 0;
    logic standby_out;
    logic fetch_start_out;
    logic [19:0] fetch_addr_out;
    logic [3:0] wait_cfg = 4'h0;
    logic [15:0] d;
    int n;
    int fail_count = 0;
    int cmp_count = 0;
    bus_pins_core i_bus_pins_core (.sys_clk_in, .sys_rst_in, .nmi_pin_in, .irq_pin_in, .bus_hold_request_in,
        .ready_pin_in, .poll_n_pin_in, .low_addr_data_pins_in, .low_addr_data_pins_out, .low_addr_data_oe_n_out,
        .mid_address_pins_out, .mid_address_oe_n_out, .address_latch_strobe_out, .irq_acknowledge_n_out,
        .buffer_output_enable_n_out, .buffer_output_enable_oe_n_out, .bus_hold_acknowledge_out, .cmd_valid_in,
        .cmd_write_in, .cmd_word_in, .cmd_addr_in, .cmd_wdata_in, .cmd_ready_out, .cmd_done_out, .cmd_rdata_out,
        .instr_last_in, .irq_enable_flag_in, .irq_take_out, .irq_vector_out, .poll_start_in, .poll_done_out,
        .standby_enter_in, .standby_out, .fetch_start_out, .fetch_addr_out);
    far_side_model i_far_side_model (.clk_in(sys_clk_in), .mid_in(mid_address_pins_out),
        .low_in(low_addr_data_pins_out), .low_oe_n_in(low_addr_data_oe_n_out), .strobe_in(address_latch_strobe_out),
        .ack_n_in(irq_acknowledge_n_out), .buffer_output_enable_n_in(buffer_output_enable_n_out), .wait_in(wait_cfg),
        .pins_out(low_addr_data_pins_in), .ready_out(ready_pin_in));
    // Clock at 200 MHz
    always #2.5 sys_clk_in = ~sys_clk_in;
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic bit hit(input int s);
        case (s)
            0: return cmd_done_out === 1'b1;
            1: return irq_take_out === 1'b1;
            2: return poll_done_out === 1'b1;
            3: return bus_hold_acknowledge_out === 1'b1;
            4: return standby_out === 1'b1;
            5: return standby_out === 1'b0;
            6: return irq_acknowledge_n_out === 1'b0;
            default: return bus_hold_acknowledge_out === 1'b0;
        endcase
    endfunction
    // Checks the current cycle first, then each later one, up to lim cycles
    task automatic wait_on(input int s, input int lim, output int k);
        k = 0;
        while (k < lim) begin
            #1;
            if (hit(s)) return;
            @(posedge sys_clk_in);
            k++;
        end
    endtask
    task automatic await(input int s, output int k);
        wait_on(s, 300, k);
        if (k == 300) begin
            fail_count++;
            $display("ERROR at %0t wait %h expected %h", $time, s, 1);
            tally_and_finish();
        end
    endtask
    task automatic pulse(input bit p);
        @(posedge sys_clk_in) {poll_start_in, instr_last_in} <= {p, !p};
        @(posedge sys_clk_in) {poll_start_in, instr_last_in} <= 2'b00;
    endtask
    function automatic logic [7:0] mem(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    task automatic bus_read(input logic [19:0] a, input logic w, output int k);
        int i = 0;
        @(posedge sys_clk_in);
        cmd_valid_in <= 1;
        cmd_addr_in <= a;
        cmd_word_in <= w;
        do @(posedge sys_clk_in); while (cmd_ready_out !== 1'b1 && ++i < 100);
        cmd_valid_in <= 0;
        await(0, k);
        d = cmd_rdata_out;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_in);
        sys_rst_in <= 0;
        @(posedge sys_clk_in);
        #1 chk({fetch_start_out, fetch_addr_out[18:0]}, {1'b1, 19'h7FFF0});
        chk(fetch_addr_out, 20'hFFFF0);
        bus_read(20'h01234, 0, n);
        chk(d[7:0], mem(20'h01234));
        $display("byte read done");
        wait_cfg <= 4'h5;
        bus_read(20'h080FF, 1, n);
        chk(d, {mem(20'h08100), mem(20'h080FF)});
        chk(n > 8, 1);
        wait_cfg <= 4'h0;
        $display("word read with waits done");
        nmi_pin_in <= 1;
        irq_pin_in <= 1;
        repeat (6) @(posedge sys_clk_in);
        nmi_pin_in <= 0;
        pulse(0);
        await(1, n);
        chk(irq_vector_out, 8'h02);
        pulse(0);
        wait_on(1, 15, n);
        chk(n, 15);
        irq_enable_flag_in <= 1;
        pulse(0);
        await(6, n);
        irq_pin_in <= 0;
        await(1, n);
        chk(irq_vector_out, 8'h5C);
        $display("interrupt test done");
        poll_n_pin_in <= 1;
        bus_hold_request_in <= 1;
        await(3, n);
        chk({low_addr_data_oe_n_out, mid_address_oe_n_out, buffer_output_enable_oe_n_out}, 3'h7);
        bus_hold_request_in <= 0;
        await(7, n);
        $display("hold test done");
        pulse(1);
        wait_on(2, 15, n);
        chk(n, 15);
        poll_n_pin_in <= 0;
        await(2, n);
        $display("poll test done");
        standby_enter_in <= 1;
        await(4, n);
        repeat (3) @(posedge sys_clk_in);
        #1 chk({irq_acknowledge_n_out, buffer_output_enable_n_out, address_latch_strobe_out}, 3'h6);
        standby_enter_in <= 0;
        nmi_pin_in <= 1;
        repeat (6) @(posedge sys_clk_in);
        nmi_pin_in <= 0;
        await(5, n);
        $display("standby test done");
        tally_and_finish();
    end
endmodule
